// ==== adc_ctrl_pkg.sv ====
// Purpose: Shared constants and types for the converter control block
// Assumes: APB slave, 32-bit data, byte-wide registers in the low bits
// Notes: Register offsets are byte addresses of aligned words
`default_nettype none
package adc_ctrl_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_RES_HIGH = 8'h04;
  localparam logic [7:0] OFS_RES_LOW = 8'h08;
  localparam logic [7:0] OFS_ANALOG_SEL = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int BIT_JUSTIFY = 7;
  localparam int BIT_REFSEL = 6;
  localparam int BIT_CHS_HI = 4;
  localparam int BIT_CHS_LO = 2;
  localparam int BIT_START = 1;
  localparam int BIT_ON = 0;
  localparam logic [7:0] CONTROL_MASK = 8'hdf;
  localparam logic [7:0] ANALOG_SEL_MASK = 8'h7f;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_ANALOG_SEL = 8'h0f;
  localparam logic [2:0] CHS_RESERVED = 3'h7;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CONV_TAD = 11;
  localparam int ABORT_TAD = 2;
  localparam int FRC_TAD_NS = 4000;
  localparam int CLK_NS = 50;
  localparam int FRC_CYCLES = (FRC_TAD_NS + CLK_NS - 1) / CLK_NS;

  typedef struct packed {
    logic       justify;
    logic       ref_ext;
    logic [2:0] channel;
    logic       start;
    logic       conv_on;
  } ctrl_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_CONV  = 4'b0010,
    ST_ABORT = 4'b0100,
    ST_ACQ   = 4'b1000
  } conv_state_t;
endpackage
`default_nettype wire

// ==== adc_tad_gen.sv ====
// Purpose: One-cycle tick per conversion bit period
// Assumes: Divider code as for the analog select register clock field
// Notes: Internal oscillator is modelled by a fixed count
`default_nettype none
module adc_tad_gen (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic run,
  input wire logic [2:0] clk_sel,
  // Tick
  output logic tick
);
  import adc_ctrl_pkg::*;
  logic [11:0] cnt_ff;
  logic [11:0] limit;

  always_comb begin
    unique case (clk_sel)
      3'h0: limit = 12'h001;
      3'h4: limit = 12'h003;
      3'h1: limit = 12'h007;
      3'h5: limit = 12'h00f;
      3'h2: limit = 12'h01f;
      3'h6: limit = 12'h03f;
      default: limit = 12'(FRC_CYCLES - 1);
    endcase
  end

  // Counter restarts with each run so periods line up with the start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 12'h000;
    end else if (!run || cnt_ff >= limit) begin
      cnt_ff <= 12'h000;
    end else begin
      cnt_ff <= cnt_ff + 12'h001;
    end
  end

  assign tick = run && (cnt_ff >= limit);
endmodule
`default_nettype wire

// ==== adc_result_fmt.sv ====
// Purpose: Place a 10-bit result in the two result bytes
// Assumes: Justification bit taken live from the control register
// Notes: Purely combinational
`default_nettype none
module adc_result_fmt (
  // Inputs
  input wire logic [9:0] result,
  input wire logic justify,
  // Formatted bytes
  output logic [7:0] high_byte,
  output logic [7:0] low_byte
);
  always_comb begin
    if (justify) begin
      high_byte = {6'h00, result[9:8]}; // R14
      low_byte = result[7:0]; // R14
    end else begin
      high_byte = result[9:2]; // R13
      low_byte = {result[1:0], 6'h00}; // R13
    end
  end
endmodule
`default_nettype wire

// ==== adc_ctrl.sv ====
// Purpose: Converter control and result registers behind an APB slave
// Assumes: Analog core returns a 10-bit sample on request
// Notes: Special event trigger arrives from same-clock logic
//
// Summary of operation
// R1: Special event sets start, clears timer
// R2: Software guarantees timing for hardware triggers
// R3: Wait acquisition after channel change
// R4: Configure first, enable, then start
// R5: Clear done flag before enabling interrupts
// R6: Poll start bit or await interrupt
// R7: Software clears done flag after reading
// R8: Top control bit picks justification
// R9: Reference select picks external pin
// R10: Channel select routes inputs and references
// R11: Start bit starts, reads busy, self-clears
// R12: Enable bit powers converter
// R13: Left-justified result byte layout
// R14: Right-justified result byte layout
// R15: Result registers are read-only
// R16: Completion clears start, sets flag, loads result
// R17: Abort keeps result, waits two periods
// R18: Conversion takes eleven bit periods
// R19: Enable in earlier write than start
// R20: Unimplemented bits read zero
`default_nettype none
module adc_ctrl (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Capture/compare special event
  input wire logic special_event,
  output logic timer_clear,
  // Analog core
  input wire logic [9:0] sample_value,
  output logic converter_on,
  output logic reference_select,
  output logic [2:0] channel_select,
  output logic sample_hold,
  // Completion
  output logic conversion_done_flag
);
  import adc_ctrl_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  ctrl_t ctrl_ff;
  logic [6:0] anasel_ff;
  logic [9:0] result_ff;
  logic done_ff;
  conv_state_t state_ff;
  logic [3:0] tad_cnt_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic timer_clear_ff;
  logic hold_ff;
  logic tad_tick;
  logic [7:0] high_byte;
  logic [7:0] low_byte;
  logic apb_setup;
  logic wr_ctrl;
  logic wr_status;
  logic sw_start;
  logic sw_abort;
  logic hw_start;
  logic conv_end;
  logic known_addr;
  logic [31:0] nxt_prdata;
  logic apb_access;
  logic wr_asel;

  assign apb_setup = psel && !penable;
  // Writes land at the access edge, when pready is seen high; answer is one cycle
  assign apb_access = psel && penable && pready_ff;
  assign wr_ctrl = apb_access && pwrite && paddr == OFS_CONTROL;
  assign wr_status = apb_access && pwrite && paddr == OFS_STATUS;
  assign wr_asel = apb_access && pwrite && paddr == OFS_ANALOG_SEL;
  assign known_addr = paddr == OFS_CONTROL || paddr == OFS_RES_HIGH ||
    paddr == OFS_RES_LOW || paddr == OFS_ANALOG_SEL || paddr == OFS_STATUS;
  // Start needs converter already on from an earlier write
  assign sw_start = wr_ctrl && pwdata[BIT_START] && !ctrl_ff.start && ctrl_ff.conv_on; // R11 R19
  assign sw_abort = wr_ctrl && ctrl_ff.start && !(pwdata[BIT_START] && pwdata[BIT_ON]); // R17
  assign hw_start = special_event && ctrl_ff.conv_on && !ctrl_ff.start; // R1
  // Abort or disable wins over a completion tick in the same cycle
  assign conv_end = state_ff == ST_CONV && tad_tick && tad_cnt_ff == 4'(CONV_TAD - 1) &&
    !sw_abort && ctrl_ff.conv_on; // R18

  // ****************************************
  // Submodules
  // ****************************************
  adc_tad_gen u_tad (
    .pclk(pclk),
    .presetn(presetn),
    .run(state_ff == ST_CONV || state_ff == ST_ABORT),
    .clk_sel(anasel_ff[6:4]),
    .tick(tad_tick)
  );

  adc_result_fmt u_fmt (
    .result(result_ff),
    .justify(ctrl_ff.justify), // R8
    .high_byte(high_byte),
    .low_byte(low_byte)
  );

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff.justify <= RST_CONTROL[BIT_JUSTIFY];
      ctrl_ff.ref_ext <= RST_CONTROL[BIT_REFSEL];
      ctrl_ff.channel <= RST_CONTROL[BIT_CHS_HI:BIT_CHS_LO];
      ctrl_ff.start <= RST_CONTROL[BIT_START];
      ctrl_ff.conv_on <= RST_CONTROL[BIT_ON];
    end else begin
      if (wr_ctrl) begin
        ctrl_ff.justify <= pwdata[BIT_JUSTIFY]; // R8
        ctrl_ff.ref_ext <= pwdata[BIT_REFSEL]; // R9
        ctrl_ff.channel <= pwdata[BIT_CHS_HI:BIT_CHS_LO]; // R10
        ctrl_ff.conv_on <= pwdata[BIT_ON]; // R12
        ctrl_ff.start <= sw_start || (ctrl_ff.start && pwdata[BIT_START] &&
          pwdata[BIT_ON]); // R11 R17
      end
      if (hw_start) begin
        ctrl_ff.start <= 1'b1; // R1
      end else if (conv_end || (!ctrl_ff.conv_on && !wr_ctrl)) begin
        ctrl_ff.start <= 1'b0; // R16
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      anasel_ff <= RST_ANALOG_SEL[6:0];
    end else if (wr_asel) begin
      anasel_ff <= pwdata[6:0];
    end
  end

  // ****************************************
  // Conversion sequencer
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
      tad_cnt_ff <= 4'h0;
    end else begin
      unique case (state_ff)
        ST_IDLE, ST_ACQ: begin
          tad_cnt_ff <= 4'h0;
          // A start set during the abort pause runs here instead of hanging
          if (sw_start || hw_start || (ctrl_ff.start && ctrl_ff.conv_on && !sw_abort)) begin
            state_ff <= ST_CONV; // R11
          end
        end
        ST_CONV: begin
          if (sw_abort || !ctrl_ff.conv_on) begin
            state_ff <= ST_ABORT; // R17
            tad_cnt_ff <= 4'h0;
          end else if (conv_end) begin
            state_ff <= ST_IDLE; // R16
            tad_cnt_ff <= 4'h0;
          end else if (tad_tick) begin
            tad_cnt_ff <= tad_cnt_ff + 4'h1; // R18
          end
        end
        ST_ABORT: begin
          if (tad_tick && tad_cnt_ff == 4'(ABORT_TAD - 1)) begin
            state_ff <= ST_ACQ; // R17
            tad_cnt_ff <= 4'h0;
          end else if (tad_tick) begin
            tad_cnt_ff <= tad_cnt_ff + 4'h1;
          end
        end
      endcase
    end
  end

  // Result loads only on a full conversion; aborts leave it untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_ff <= 10'h000;
    end else if (conv_end) begin
      result_ff <= sample_value; // R16 R15
    end
  end

  // Set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_ff <= 1'b0;
    end else if (conv_end) begin
      done_ff <= 1'b1; // R16
    end else if (wr_status && pwdata[0]) begin
      done_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_clear_ff <= 1'b0;
    end else begin
      timer_clear_ff <= special_event && ctrl_ff.conv_on; // R1
    end
  end

  // Hold is released while acquiring so the input can settle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_ff <= 1'b0;
    end else begin
      hold_ff <= state_ff == ST_CONV && ctrl_ff.conv_on;
    end
  end

  // ****************************************
  // APB read path
  // ****************************************
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    unique case (paddr)
      OFS_CONTROL: nxt_prdata = {24'h00_0000, ctrl_ff.justify, ctrl_ff.ref_ext, 1'b0,
        ctrl_ff.channel, ctrl_ff.start, ctrl_ff.conv_on} & {24'h00_0000, CONTROL_MASK}; // R20
      OFS_RES_HIGH: nxt_prdata = {24'h00_0000, high_byte}; // R13 R14
      OFS_RES_LOW: nxt_prdata = {24'h00_0000, low_byte}; // R13 R14
      OFS_ANALOG_SEL: nxt_prdata = {25'h000_0000, anasel_ff}; // R20
      OFS_STATUS: nxt_prdata = {31'h0000_0000, done_ff};
      default: nxt_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= apb_setup;
      pslverr_ff <= apb_setup && !known_addr;
      prdata_ff <= (apb_setup && !pwrite) ? nxt_prdata : 32'h0000_0000;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign timer_clear = timer_clear_ff;
  assign sample_hold = hold_ff;
  assign converter_on = ctrl_ff.conv_on; // R12
  assign reference_select = ctrl_ff.ref_ext; // R9
  assign channel_select = ctrl_ff.channel; // R10
  assign conversion_done_flag = done_ff;

  // ****************************************
  // Checks
  // ****************************************
  // Length cross-check; skipped when the clock choice moves mid-conversion
  logic [11:0] conv_cyc_ff;
  logic clk_moved_ff;
  logic [11:0] tad_len;
  always_comb begin
    unique case (anasel_ff[6:4])
      3'h0: tad_len = 12'h002;
      3'h4: tad_len = 12'h004;
      3'h1: tad_len = 12'h008;
      3'h5: tad_len = 12'h010;
      3'h2: tad_len = 12'h020;
      3'h6: tad_len = 12'h040;
      default: tad_len = 12'(FRC_CYCLES);
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_cyc_ff <= 12'h000;
      clk_moved_ff <= 1'b0;
    end else if (state_ff != ST_CONV) begin
      conv_cyc_ff <= 12'h000;
      clk_moved_ff <= 1'b0;
    end else begin
      conv_cyc_ff <= conv_cyc_ff + 12'h001;
      clk_moved_ff <= clk_moved_ff || wr_asel;
    end
  end

  sequence s_complete;
    conv_end ##1 (!ctrl_ff.start && done_ff);
  endsequence

  property p_hw_start;
    @(posedge pclk) disable iff (!presetn)
      hw_start |=> ctrl_ff.start && timer_clear;
  endproperty
  a_hw_start: assert property (p_hw_start) else $error("trigger start missed"); // R1

  property p_complete;
    @(posedge pclk) disable iff (!presetn)
      conv_end && !hw_start |-> s_complete;
  endproperty
  a_complete: assert property (p_complete) else $error("completion effects missing"); // R16

  property p_result_load;
    @(posedge pclk) disable iff (!presetn)
      conv_end |=> result_ff == $past(sample_value);
  endproperty
  a_result_load: assert property (p_result_load) else $error("result not loaded"); // R16

  property p_abort_keep;
    @(posedge pclk) disable iff (!presetn)
      state_ff == ST_ABORT |-> $stable(result_ff);
  endproperty
  a_abort_keep: assert property (p_abort_keep) else $error("abort changed result"); // R17

  property p_busy;
    @(posedge pclk) disable iff (!presetn)
      state_ff == ST_CONV && $past(state_ff) == ST_CONV |-> ctrl_ff.start;
  endproperty
  a_busy: assert property (p_busy) else $error("start low while busy"); // R11

  property p_ticks;
    @(posedge pclk) disable iff (!presetn)
      conv_end && !clk_moved_ff |-> conv_cyc_ff == 12'(CONV_TAD) * tad_len - 12'h001;
  endproperty
  a_ticks: assert property (p_ticks) else $error("wrong conversion length"); // R18

  property p_left;
    @(posedge pclk) disable iff (!presetn)
      !ctrl_ff.justify |-> low_byte[5:0] == 6'h00 && high_byte == result_ff[9:2];
  endproperty
  a_left: assert property (p_left) else $error("left format wrong"); // R13

  property p_right;
    @(posedge pclk) disable iff (!presetn)
      ctrl_ff.justify |-> high_byte[7:2] == 6'h00 && low_byte == result_ff[7:0];
  endproperty
  a_right: assert property (p_right) else $error("right format wrong"); // R14

  property p_ro;
    @(posedge pclk) disable iff (!presetn)
      !conv_end |=> $stable(result_ff);
  endproperty
  a_ro: assert property (p_ro) else $error("result changed by write"); // R15

  property p_rsvd;
    @(posedge pclk) disable iff (!presetn)
      pready && $past(paddr) == OFS_CONTROL && !$past(pwrite) |-> prdata[5] == 1'b0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit nonzero"); // R20

  property p_off_idle;
    @(posedge pclk) disable iff (!presetn)
      !ctrl_ff.conv_on |-> state_ff != ST_CONV;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("converting while disabled"); // R12
endmodule
`default_nettype wire

// ==== tb_adc_ctrl.sv ====
// Purpose: Self-checking bench for the converter control block
// Assumes: APB answer comes one cycle after setup, as handed over
// Notes: Conversion length is checked within a small polling window
`default_nettype none
module tb_adc_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_ctrl_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic special_event = 1'b0;
  logic timer_clear;
  logic [9:0] sample_value = 10'h000;
  logic converter_on;
  logic reference_select;
  logic [2:0] channel_select;
  logic sample_hold;
  logic conversion_done_flag;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [15:0] lf = 16'h001e;
  logic [9:0] raw_m;
  adc_ctrl u_adc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .special_event(special_event), .timer_clear(timer_clear),
    .sample_value(sample_value), .converter_on(converter_on),
    .reference_select(reference_select), .channel_select(channel_select),
    .sample_hold(sample_hold), .conversion_done_flag(conversion_done_flag));
  always #25 pclk = ~pclk;
  // ****************************************
  // Helpers
  // ****************************************
  task automatic close_out();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Ceiling well above the slowest clock setting's run
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] fmt(input logic j, input logic [9:0] r);
    return j ? {6'h00, r} : {r, 6'h00};
  endfunction
  // Caller stands just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdat, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge keeps back-to-back calls from redriving psel in one step
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    logic e;
    apb(1'b1, a, wd, x, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    logic e;
    apb(1'b0, a, 32'h0, x, e);
  endtask
  task automatic check_res(input logic j);
    logic [31:0] d;
    logic [15:0] f;
    f = fmt(j, raw_m);
    rd(OFS_RES_HIGH, d);
    chk("res_high", {24'h0, f[15:8]}, d);
    rd(OFS_RES_LOW, d);
    chk("res_low", {24'h0, f[7:0]}, d);
  endtask
  task automatic convert(input logic [2:0] cs, input int div, input logic j, input logic evt);
    logic [31:0] d;
    int t0;
    int n;
    int len;
    lf = lfsr_next(lf);
    sample_value <= lf[9:0];
    wr(OFS_ANALOG_SEL, {25'h0, cs, 4'hf});
    wr(OFS_STATUS, 32'h1);
    wr(OFS_CONTROL, {24'h0, j, 7'h01});
    repeat (100) @(posedge pclk);
    t0 = cyc;
    if (evt) begin
      special_event <= 1'b1;
      @(posedge pclk);
      special_event <= 1'b0;
      #1;
      chk("timer_clear", 32'h1, timer_clear);
      @(posedge pclk);
    end else begin
      wr(OFS_CONTROL, {24'h0, j, 7'h03});
    end
    rd(OFS_CONTROL, d);
    chk("busy", {24'h0, j, 7'h03}, d);
    chk("hold", 32'h1, sample_hold);
    n = 0;
    while (d[1] === 1'b1 && n < 500) begin
      rd(OFS_CONTROL, d);
      n++;
    end
    raw_m = lf[9:0];
    chk("done_ctrl", {24'h0, j, 7'h01}, d);
    len = cyc - t0;
    chk("conv_len", 32'h1, len >= CONV_TAD * div && len <= CONV_TAD * div + 12);
    check_res(j);
    rd(OFS_STATUS, d);
    chk("done_flag", 32'h1, d);
    chk("done_pin", 32'h1, conversion_done_flag);
    // Justification applies live to the stored result
    wr(OFS_CONTROL, {24'h0, ~j, 7'h01});
    check_res(~j);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  logic [2:0] codes [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
  int divs [7] = '{2, 4, 8, 16, 32, 64, FRC_CYCLES};
  initial begin
    logic [31:0] d;
    logic [7:0] w;
    logic e;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFS_CONTROL, d);
    chk("ctrl_rst", {24'h0, RST_CONTROL}, d);
    rd(OFS_ANALOG_SEL, d);
    chk("asel_rst", {24'h0, RST_ANALOG_SEL}, d);
    special_event <= 1'b1;
    @(posedge pclk);
    special_event <= 1'b0;
    #1;
    chk("evt_off", 32'h0, timer_clear);
    @(posedge pclk);
    wr(OFS_CONTROL, 32'hff);
    rd(OFS_CONTROL, d);
    chk("start_refused", 32'hdd, d);
    chk("hold_idle", 32'h0, sample_hold);
    for (int i = 0; i < 7; i++) begin
      lf = lfsr_next(lf);
      w = {lf[7:5], i[2:0], 2'b01};
      wr(OFS_CONTROL, {24'h0, w});
      rd(OFS_CONTROL, d);
      chk("ctrl_rw", {24'h0, w & CONTROL_MASK}, d);
      chk("ref_sel", {31'h0, w[6]}, reference_select);
      chk("chan_sel", i, channel_select);
      chk("conv_on", 32'h1, converter_on);
    end
    for (int i = 0; i < 7; i++) begin
      convert(codes[i], divs[i], i[0], i[1]);
    end
    // Abort keeps the old result and raises no flag
    wr(OFS_ANALOG_SEL, {24'h0, RST_ANALOG_SEL});
    wr(OFS_STATUS, 32'h1);
    rd(OFS_STATUS, d);
    chk("flag_clear", 32'h0, d);
    sample_value <= ~raw_m;
    wr(OFS_CONTROL, 32'h81);
    wr(OFS_CONTROL, 32'h83);
    wr(OFS_CONTROL, 32'h81);
    repeat (40) @(posedge pclk);
    check_res(1'b1);
    rd(OFS_STATUS, d);
    chk("abort_flag", 32'h0, d);
    chk("abort_hold", 32'h0, sample_hold);
    wr(OFS_RES_HIGH, 32'hffffffff);
    wr(OFS_RES_LOW, 32'hffffffff);
    check_res(1'b1);
    apb(1'b0, 8'h20, 32'h0, d, e);
    chk("unmapped_err", 32'h1, e);
    chk("unmapped_data", 32'h0, d);
    wr(OFS_CONTROL, 32'h00);
    @(posedge pclk);
    chk("conv_off", 32'h0, converter_on);
    close_out();
  end
endmodule
`default_nettype wire
